/* File: verilog/dcc_channel_regs.v */
//Contract
// RULE_01: Power-down bit 8 resets set, clearing powers up.
// RULE_02: Enable low disables channel, clears held code immediately.
// RULE_03: Software must set enable before expecting output.
// RULE_04: Range field 00 internal, 11 supply rails.
// RULE_05: Range field writes act at once, unstaged.
// RULE_06: Channel five drive bit 10, 300 ohm load.
// RULE_07: Channel five heavy-load bit 9, 10 nF load.
// RULE_08: Control registers 16 bits, reset 0x0100.
// RULE_09: Code registers hold 12-bit code in [27:16].
// RULE_10: Software writes zero to reserved bits, codes.
`timescale 1ns/1ps
`include "dcc_defines.vh"
`default_nettype none

module dcc_channel_regs
(
    // Clock and reset
    input  wire                      clk_sys,
    input  wire                      rst_n,
    // Enables of channels zero to two from their control registers
    input  wire                      ch0_enable,
    input  wire                      ch1_enable,
    input  wire                      ch2_enable,
    // AXI4-Lite write address channel
    input  wire [`DCC_ADDR_W-1:0]    s_axi_awaddr,
    input  wire [2:0]                s_axi_awprot,
    input  wire                      s_axi_awvalid,
    output wire                      s_axi_awready,
    // AXI4-Lite write data channel
    input  wire [`DCC_DATA_W-1:0]    s_axi_wdata,
    input  wire [`DCC_STRB_W-1:0]    s_axi_wstrb,
    input  wire                      s_axi_wvalid,
    output wire                      s_axi_wready,
    // AXI4-Lite write response channel
    output wire [1:0]                s_axi_bresp,
    output wire                      s_axi_bvalid,
    input  wire                      s_axi_bready,
    // AXI4-Lite read address channel
    input  wire [`DCC_ADDR_W-1:0]    s_axi_araddr,
    input  wire [2:0]                s_axi_arprot,
    input  wire                      s_axi_arvalid,
    output wire                      s_axi_arready,
    // AXI4-Lite read data channel
    output wire [`DCC_DATA_W-1:0]    s_axi_rdata,
    output wire [1:0]                s_axi_rresp,
    output wire                      s_axi_rvalid,
    input  wire                      s_axi_rready,
    // Channel five converter controls
    output wire                      ch5_power_down,
    output wire                      ch5_enable,
    output wire [1:0]                ch5_range_select,
    output wire                      ch5_strong_drive,
    output wire                      ch5_heavy_load,
    // Channel six converter controls
    output wire                      ch6_power_down,
    output wire                      ch6_enable,
    output wire [1:0]                ch6_range_select,
    // Channel seven converter controls
    output wire                      ch7_power_down,
    output wire                      ch7_enable,
    output wire [1:0]                ch7_range_select,
    // Output codes of channels zero to two
    output wire [`DCC_CODE_W-1:0]    ch0_output_code,
    output wire [`DCC_CODE_W-1:0]    ch1_output_code,
    output wire [`DCC_CODE_W-1:0]    ch2_output_code
);

    // Bus handshake state.
    reg                      awready_q;
    reg                      wready_q;
    reg                      aw_full_q;
    reg                      w_full_q;
    reg [`DCC_ADDR_W-1:0]    aw_addr_q;
    reg [`DCC_DATA_W-1:0]    w_data_q;
    reg [`DCC_STRB_W-1:0]    w_strb_q;
    reg                      bvalid_q;
    reg [1:0]                bresp_q;
    reg                      arready_q;
    reg                      rvalid_q;
    reg [1:0]                rresp_q;
    reg [`DCC_DATA_W-1:0]    rdata_q;

    // Register contents.
    reg [`DCC_CTRL_W-1:0]    ctrl5_q;
    reg [`DCC_CTRL_W-1:0]    ctrl6_q;
    reg [`DCC_CTRL_W-1:0]    ctrl7_q;
    reg [`DCC_CODE_W-1:0]    code0_q;
    reg [`DCC_CODE_W-1:0]    code1_q;
    reg [`DCC_CODE_W-1:0]    code2_q;

    // Write path combinational signals.
    wire                     aw_take;
    wire                     w_take;
    wire                     aw_full_d;
    wire                     w_full_d;
    wire [`DCC_ADDR_W-1:0]   wr_addr;
    wire [`DCC_DATA_W-1:0]   wr_data;
    wire [`DCC_STRB_W-1:0]   wr_strb;
    wire                     do_write;
    wire                     aw_full_next;
    wire                     w_full_next;
    wire                     wr_hit;
    wire [`DCC_DATA_W-1:0]   ctrl5_new;
    wire [`DCC_DATA_W-1:0]   ctrl6_new;
    wire [`DCC_DATA_W-1:0]   ctrl7_new;
    wire [`DCC_DATA_W-1:0]   code0_new;
    wire [`DCC_DATA_W-1:0]   code1_new;
    wire [`DCC_DATA_W-1:0]   code2_new;

    // Read path combinational signals.
    wire                     ar_take;
    wire                     rvalid_next;
    reg  [`DCC_DATA_W-1:0]   rd_mux;
    reg                      rd_hit;

    // Merges written bytes into a word, touching only writable bits.
    function [`DCC_DATA_W-1:0] merge_word;
        input [`DCC_DATA_W-1:0] old_word;
        input [`DCC_DATA_W-1:0] new_word;
        input [`DCC_STRB_W-1:0] strb;
        input [`DCC_DATA_W-1:0] wmask;
        reg   [`DCC_DATA_W-1:0] lanes;
        integer                 i;
        begin
            lanes = `DCC_ZERO32;
            for (i = 0; i < `DCC_STRB_W; i = i + 1)
            begin
                lanes[i*8 +: 8] = {8{strb[i]}};
            end
            merge_word = (old_word & ~(lanes & wmask)) | (new_word & lanes & wmask);
        end
    endfunction

    assign aw_take      = s_axi_awvalid & awready_q;
    assign w_take       = s_axi_wvalid & wready_q;
    assign aw_full_d    = aw_full_q | aw_take;
    assign w_full_d     = w_full_q | w_take;
    assign wr_addr      = aw_take ? s_axi_awaddr : aw_addr_q;
    assign wr_data      = w_take ? s_axi_wdata : w_data_q;
    assign wr_strb      = w_take ? s_axi_wstrb : w_strb_q;
    // A new response waits until the previous one has been taken.
    assign do_write     = aw_full_d & w_full_d & (~bvalid_q | s_axi_bready);
    assign aw_full_next = aw_full_d & ~do_write;
    assign w_full_next  = w_full_d & ~do_write;

    assign wr_hit = (wr_addr == `DCC_ADDR_CH5_CTRL) | (wr_addr == `DCC_ADDR_CH6_CTRL) |
                    (wr_addr == `DCC_ADDR_CH7_CTRL) | (wr_addr == `DCC_ADDR_CH0_CODE) |
                    (wr_addr == `DCC_ADDR_CH1_CODE) | (wr_addr == `DCC_ADDR_CH2_CODE);

    // Bits above the write masks stay zero; reserved control bits 2, 3 and 5 to 7 lie inside the masks and keep what is written.
    assign ctrl5_new = merge_word({16'h0000, ctrl5_q}, wr_data, wr_strb,
                                  `DCC_CTRL5_WMASK); // see RULE_06 see RULE_07
    assign ctrl6_new = merge_word({16'h0000, ctrl6_q}, wr_data, wr_strb, `DCC_CTRL67_WMASK);
    assign ctrl7_new = merge_word({16'h0000, ctrl7_q}, wr_data, wr_strb, `DCC_CTRL67_WMASK);
    assign code0_new = merge_word({4'h0, code0_q, 16'h0000}, wr_data, wr_strb,
                                  `DCC_CODE_WMASK); // see RULE_09
    assign code1_new = merge_word({4'h0, code1_q, 16'h0000}, wr_data, wr_strb,
                                  `DCC_CODE_WMASK);
    assign code2_new = merge_word({4'h0, code2_q, 16'h0000}, wr_data, wr_strb,
                                  `DCC_CODE_WMASK);

    assign ar_take     = s_axi_arvalid & arready_q;
    assign rvalid_next = ar_take | (rvalid_q & ~s_axi_rready);

    always @*
    begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `DCC_ADDR_CH5_CTRL: rd_mux = {16'h0000, ctrl5_q};
            `DCC_ADDR_CH6_CTRL: rd_mux = {16'h0000, ctrl6_q};
            `DCC_ADDR_CH7_CTRL: rd_mux = {16'h0000, ctrl7_q};
            `DCC_ADDR_CH0_CODE: rd_mux = {4'h0, code0_q, 16'h0000}; // see RULE_09
            `DCC_ADDR_CH1_CODE: rd_mux = {4'h0, code1_q, 16'h0000};
            `DCC_ADDR_CH2_CODE: rd_mux = {4'h0, code2_q, 16'h0000};
            default:
            begin
                rd_mux = `DCC_ZERO32;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Write channel handshakes; address and data are taken in either order.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            aw_addr_q <= `DCC_ZERO32;
            w_data_q  <= `DCC_ZERO32;
            w_strb_q  <= {`DCC_STRB_W{1'b0}};
            bvalid_q  <= 1'b0;
            bresp_q   <= `DCC_RESP_OKAY;
        end
        else
        begin
            awready_q <= ~aw_full_next;
            wready_q  <= ~w_full_next;
            aw_full_q <= aw_full_next;
            w_full_q  <= w_full_next;
            if (aw_take)
            begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read channel: one outstanding read, answered the cycle after it is taken.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= `DCC_RESP_OKAY;
            rdata_q   <= `DCC_ZERO32;
        end
        else
        begin
            arready_q <= ~rvalid_next;
            rvalid_q  <= rvalid_next;
            if (ar_take)
            begin
                rdata_q <= rd_mux;
                rresp_q <= rd_hit ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
            end
        end
    end

    // Control registers drive the converters directly, so a range write lands
    // on the analogue side on the same edge that raises the write response.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl5_q <= `DCC_CTRL_RESET; // see RULE_01 see RULE_08
            ctrl6_q <= `DCC_CTRL_RESET; // see RULE_08
            ctrl7_q <= `DCC_CTRL_RESET; // see RULE_08
        end
        else if (do_write)
        begin
            if (wr_addr == `DCC_ADDR_CH5_CTRL)
            begin
                ctrl5_q <= ctrl5_new[`DCC_CTRL_W-1:0]; // see RULE_05
            end
            if (wr_addr == `DCC_ADDR_CH6_CTRL)
            begin
                ctrl6_q <= ctrl6_new[`DCC_CTRL_W-1:0]; // see RULE_05
            end
            if (wr_addr == `DCC_ADDR_CH7_CTRL)
            begin
                ctrl7_q <= ctrl7_new[`DCC_CTRL_W-1:0]; // see RULE_05
            end
        end
    end

    // A disabled channel holds its code at zero; the clear beats a write.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            code0_q <= `DCC_CODE_RESET;
            code1_q <= `DCC_CODE_RESET;
            code2_q <= `DCC_CODE_RESET;
        end
        else
        begin
            if (!ch0_enable)
            begin
                code0_q <= `DCC_CODE_RESET; // see RULE_02
            end
            else if (do_write && wr_addr == `DCC_ADDR_CH0_CODE)
            begin
                code0_q <= code0_new[`DCC_CODE_HI:`DCC_CODE_LO];
            end
            if (!ch1_enable)
            begin
                code1_q <= `DCC_CODE_RESET; // see RULE_02
            end
            else if (do_write && wr_addr == `DCC_ADDR_CH1_CODE)
            begin
                code1_q <= code1_new[`DCC_CODE_HI:`DCC_CODE_LO];
            end
            if (!ch2_enable)
            begin
                code2_q <= `DCC_CODE_RESET; // see RULE_02
            end
            else if (do_write && wr_addr == `DCC_ADDR_CH2_CODE)
            begin
                code2_q <= code2_new[`DCC_CODE_HI:`DCC_CODE_LO];
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // Reserved range codes are passed through; the analogue side treats them as undefined.
    assign ch5_power_down   = ctrl5_q[`DCC_CTRL_PDOWN_BIT]; // see RULE_01
    assign ch5_enable       = ctrl5_q[`DCC_CTRL_ENABLE_BIT]; // see RULE_02
    assign ch5_range_select = ctrl5_q[`DCC_CTRL_RANGE_HI:`DCC_CTRL_RANGE_LO]; // see RULE_04
    assign ch5_strong_drive = ctrl5_q[`DCC_CTRL_DRIVE_BIT]; // see RULE_06
    assign ch5_heavy_load   = ctrl5_q[`DCC_CTRL_HEAVY_BIT]; // see RULE_07
    assign ch6_power_down   = ctrl6_q[`DCC_CTRL_PDOWN_BIT]; // see RULE_01
    assign ch6_enable       = ctrl6_q[`DCC_CTRL_ENABLE_BIT]; // see RULE_02
    assign ch6_range_select = ctrl6_q[`DCC_CTRL_RANGE_HI:`DCC_CTRL_RANGE_LO]; // see RULE_04
    assign ch7_power_down   = ctrl7_q[`DCC_CTRL_PDOWN_BIT]; // see RULE_01
    assign ch7_enable       = ctrl7_q[`DCC_CTRL_ENABLE_BIT]; // see RULE_02
    assign ch7_range_select = ctrl7_q[`DCC_CTRL_RANGE_HI:`DCC_CTRL_RANGE_LO]; // see RULE_04
    assign ch0_output_code  = code0_q;
    assign ch1_output_code  = code1_q;
    assign ch2_output_code  = code2_q;

endmodule

`default_nettype wire

/* File: pkg/dcc_defines.vh */
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH

// Byte addresses of the registers on the peripheral bus.
`define DCC_ADDR_CH5_CTRL     32'h40082414
`define DCC_ADDR_CH6_CTRL     32'h40082418
`define DCC_ADDR_CH7_CTRL     32'h4008241c
`define DCC_ADDR_CH0_CODE     32'h40086404
`define DCC_ADDR_CH1_CODE     32'h40086408
`define DCC_ADDR_CH2_CODE     32'h4008640c

// Control register layout.
`define DCC_CTRL_W            16
`define DCC_CTRL_RESET        16'h0100
`define DCC_CTRL_RANGE_LO     0
`define DCC_CTRL_RANGE_HI     1
`define DCC_CTRL_ENABLE_BIT   4
`define DCC_CTRL_PDOWN_BIT    8
`define DCC_CTRL_HEAVY_BIT    9
`define DCC_CTRL_DRIVE_BIT    10
`define DCC_CTRL5_WMASK       32'h000007ff
`define DCC_CTRL67_WMASK      32'h000001ff

// Range codes.
`define DCC_RANGE_INTERNAL    2'h0
`define DCC_RANGE_SUPPLY      2'h3

// Code register layout.
`define DCC_CODE_W            12
`define DCC_CODE_LO           16
`define DCC_CODE_HI           27
`define DCC_CODE_RESET        12'h000
`define DCC_CODE_WMASK        32'h0fff0000

// Bus constants.
`define DCC_DATA_W            32
`define DCC_ADDR_W            32
`define DCC_STRB_W            4
`define DCC_RESP_OKAY         2'h0
`define DCC_RESP_SLVERR       2'h2
`define DCC_ZERO32            32'h00000000

`endif

/* File: verification/dcc_channel_regs_chk.sv */
`timescale 1ns/1ps
`include "dcc_defines.vh"
`default_nettype none

module dcc_channel_regs_chk
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // Bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Converter controls
    input wire logic        ch0_enable,
    input wire logic [11:0] ch0_output_code,
    input wire logic        ch5_power_down,
    input wire logic        ch5_enable,
    input wire logic [1:0]  ch5_range_select,
    input wire logic        ch5_strong_drive,
    input wire logic        ch5_heavy_load
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // The slave keeps its write readies up after a completed write, so the next
    // write may be offered as soon as the response has been taken.
    a_write_answer: assert property (s_wr_taken ##0 (!s_axi_bvalid || s_axi_bready)
        |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write not answered one cycle after it was taken");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered one cycle after it was taken");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was accepted");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before it was accepted");
    // Controls may only move on the edge that completes a write, never later.
    a_ctrl_on_write: assert property (!$stable({ch5_strong_drive, ch5_heavy_load, ch5_power_down,
        ch5_enable, ch5_range_select}) |-> $rose(s_axi_bvalid))
        else $error("channel five controls changed away from a write");
    a_clear_code: assert property (!ch0_enable |=> ch0_output_code == 12'h000)
        else $error("code not cleared while enable low");
    a_code_gated: assert property (ch0_output_code != 12'h000 |-> $past(ch0_enable))
        else $error("code nonzero after enable low");
    a_pd_reset: assert property ($rose(rst_n) |-> ch5_power_down && !ch5_enable &&
        !ch5_strong_drive && !ch5_heavy_load && ch5_range_select == 2'h0)
        else $error("channel five controls not at reset values");
endmodule

bind dcc_channel_regs dcc_channel_regs_chk u_dcc_channel_regs_chk
(
    .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ch0_enable(ch0_enable),
    .ch0_output_code(ch0_output_code), .ch5_power_down(ch5_power_down),
    .ch5_enable(ch5_enable), .ch5_range_select(ch5_range_select),
    .ch5_strong_drive(ch5_strong_drive), .ch5_heavy_load(ch5_heavy_load)
);

`default_nettype wire

/* File: verification/tb_dcc_channel_regs.sv */
`timescale 1ns/1ps
`include "dcc_defines.vh"
`default_nettype none

module tb_dcc_channel_regs;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  ch_en = 3'h0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    wire  [5:0]  c5;
    wire  [3:0]  c6, c7;
    wire  [11:0] code [0:2];
    logic [31:0] shadow [6];
    logic [31:0] addr_t [6] = '{`DCC_ADDR_CH5_CTRL, `DCC_ADDR_CH6_CTRL, `DCC_ADDR_CH7_CTRL,
                                `DCC_ADDR_CH0_CODE, `DCC_ADDR_CH1_CODE, `DCC_ADDR_CH2_CODE};
    logic [31:0] mask_t [6] = '{`DCC_CTRL5_WMASK, `DCC_CTRL67_WMASK, `DCC_CTRL67_WMASK,
                                `DCC_CODE_WMASK, `DCC_CODE_WMASK, `DCC_CODE_WMASK};
    int          fail_count = 0, n_checks = 0, cyc = 0;

    dcc_channel_regs u_dcc_channel_regs
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .ch0_enable(ch_en[0]), .ch1_enable(ch_en[1]),
        .ch2_enable(ch_en[2]), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ch5_power_down(c5[3]),
        .ch5_enable(c5[2]), .ch5_range_select(c5[1:0]), .ch5_strong_drive(c5[5]),
        .ch5_heavy_load(c5[4]), .ch6_power_down(c6[3]), .ch6_enable(c6[2]),
        .ch6_range_select(c6[1:0]), .ch7_power_down(c7[3]), .ch7_enable(c7[2]),
        .ch7_range_select(c7[1:0]), .ch0_output_code(code[0]),
        .ch1_output_code(code[1]), .ch2_output_code(code[2])
    );

    always #50 clk_sys = ~clk_sys;

    // A few thousand cycles is far beyond the longest run of transfers below.
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fail_count++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_word({30'h0, got}, {30'h0, exp});
    endtask

    function automatic logic [31:0] merge(input logic [31:0] o, n, m, input logic [3:0] s);
        logic [31:0] b;
        b = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & m;
        return (o & ~b) | (n & b);
    endfunction

    // Software leaves reserved bits at zero and uses only the two defined range codes.
    function automatic logic [31:0] legal(input int i, input logic [31:0] d);
        logic [31:0] m;
        m = (i == 0) ? 32'h00000713 : (i < 3) ? 32'h00000113 : `DCC_CODE_WMASK;
        legal = d & m;
        if (i < 3 && ^legal[1:0])
            legal[1:0] = 2'h3;
    endfunction

    task automatic axi_write(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] r);
        logic done;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'($urandom);
        do
        begin
            @(posedge clk_sys);
            done = bvalid && bready;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (!bready)
                bready <= 1'($urandom);
        end while (!done);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'($urandom);
        do
        begin
            @(posedge clk_sys);
            done = rvalid && rready;
            if (arready)
                arvalid <= 1'b0;
            if (!rready)
                rready <= 1'($urandom);
        end while (!done);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr_chk(input int i, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        axi_write(addr_t[i], d, s, r);
        chk_resp(r, `DCC_RESP_OKAY);
        if (i < 3 || ch_en[i - 3])
            shadow[i] = merge(shadow[i], d, mask_t[i], s);
    endtask

    task automatic rd_chk(input int i);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(addr_t[i], d, r);
        chk_word(d, shadow[i]);
        chk_resp(r, `DCC_RESP_OKAY);
    endtask

    task automatic pins_chk();
        @(negedge clk_sys);
        chk_word(32'(c5), 32'({shadow[0][10:8], shadow[0][4], shadow[0][1:0]}));
        chk_word(32'(c6), 32'({shadow[1][8], shadow[1][4], shadow[1][1:0]}));
        chk_word(32'(c7), 32'({shadow[2][8], shadow[2][4], shadow[2][1:0]}));
        for (int k = 0; k < 3; k++)
            chk_word(32'(code[k]), 32'(shadow[k + 3][27:16]));
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
            shadow[i] = (i < 3) ? {16'h0, `DCC_CTRL_RESET} : `DCC_ZERO32;
    endtask

    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        int          i;
        int          k;
        d = $urandom(44);
        do_reset();
        for (i = 0; i < 6; i++)
            rd_chk(i);
        pins_chk();
        $display("test reset values done");
        @(posedge clk_sys);
        ch_en <= 3'h7;
        for (i = 0; i < 24; i++)
        begin
            d = legal(i % 3, $urandom);
            d[1:0] = {2{i[1]}};
            wr_chk(i % 3, d, 4'hf);
            pins_chk();
            rd_chk(i % 3);
        end
        $display("test range codes done");
        for (i = 0; i < 40; i++)
        begin
            k = $urandom % 6;
            d = legal(k, $urandom);
            wr_chk(k, d, 4'($urandom));
            pins_chk();
            rd_chk(k);
        end
        $display("test random writes done");
        wr_chk(3, 32'h0fff0000, 4'hf);
        @(posedge clk_sys);
        ch_en <= 3'h2;
        @(posedge clk_sys);
        shadow[3] = `DCC_ZERO32;
        shadow[5] = `DCC_ZERO32;
        pins_chk();
        wr_chk(3, 32'h0abc0000, 4'hf);
        rd_chk(3);
        $display("test enable clear done");
        axi_write(32'h40082410, 32'hffffffff, 4'hf, r);
        chk_resp(r, `DCC_RESP_SLVERR);
        axi_read(32'h40086400, d, r);
        chk_resp(r, `DCC_RESP_SLVERR);
        chk_word(d, `DCC_ZERO32);
        for (i = 0; i < 6; i++)
            rd_chk(i);
        $display("test unmapped done");
        do_reset();
        for (i = 0; i < 6; i++)
            rd_chk(i);
        pins_chk();
        $display("test second reset done");
        results();
    end
endmodule

`default_nettype wire
